/* logic/spimsp_defines.svh */
// Purpose: Constants for the serial master/slave port
// Assumes: Core clock 100 MHz
// Notes: Included by the buffer and core design files
// Overview of operation
// - Master drives serial clock per control bits
// - Master and enable stay only while select high
// - Master data write loads, shifts out MSB first
// - Byte done sets flag, interrupt if enabled
// - Status access then data access clears done
// - Data writes ignored while done, until status access
// - Slave shifts data out MSB first on clock
// - Polarity and phase select capture edge
// - Low select in master sets fault, drops bits
// - Status read then control write clears fault
// - Fault blocks setting enable and master bits
// - Byte done while done flag set gives overrun
// - Overrun keeps first byte, drops later ones
// - Status read clears overrun
// - Data write during transfer sets collision
// - Receive buffer read synchronously, no collision
// - Phase selects first or second capture edge
// - Rate field divides clock by 4 to 128
`ifndef SPIMSP_DEFINES_SVH
`define SPIMSP_DEFINES_SVH
`define SPIMSP_CTL_IRQ_EN 7
`define SPIMSP_CTL_ENABLE 6
`define SPIMSP_CTL_RATE2 5
`define SPIMSP_CTL_MASTER 4
`define SPIMSP_CTL_CLOCK_POLARITY 3
`define SPIMSP_CTL_CLOCK_PHASE 2
`define SPIMSP_CSR_DONE 7
`define SPIMSP_CSR_WRITE_COLLISION_FLAG 6
`define SPIMSP_CSR_OVR 5
`define SPIMSP_CSR_MODE_FAULT_FLAG 4
`define SPIMSP_CSR_SSM 1
`define SPIMSP_CSR_SSI 0
`define SPIMSP_CTL_RESET 8'h00
`define SPIMSP_CSR_RESET 8'h00
`define SPIMSP_BITS 4'h8
`define SPIMSP_FIFO_DEPTH 2
`endif

/* logic/spimsp_pkg.sv */
// Purpose: Types for the serial master/slave port
// Assumes: Nothing beyond the defines header
// Notes: No constants live here
package spimsp_pkg;
  typedef enum logic [2:0] {
    SPIMSP_IDLE = 3'b001,
    SPIMSP_SHIFT = 3'b010,
    SPIMSP_DONE = 3'b100
  } spimsp_state_t;
  typedef struct packed {
    logic clk;
    logic mosi;
    logic miso;
    logic sel_n;
  } spimsp_pins_t;
endpackage

/* logic/spimsp_buf.sv */
// Purpose: Two-entry receive buffer, valid/ready both sides
// Assumes: Same clock on both sides
// Notes: Full and empty are exact
`timescale 1ns/100ps
`default_nettype none
`include "spimsp_defines.svh"
module spimsp_buf (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [7:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [7:0] out_data_out
);
  logic [7:0] mem_reg [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data_in;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  buf_never_over_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    count_reg <= 2'h2) else $error("buffer count out of range");
endmodule
`default_nettype wire

/* logic/spimsp_core.sv */
// Purpose: Byte-wide serial port, master or slave, with flags
// Assumes: Serial pins are asynchronous and pass two flip-flops
// Notes: Register accesses arrive as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
`include "spimsp_defines.svh"
module spimsp_core (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register strobes
  input wire logic ctl_wr_in,
  input wire logic csr_wr_in,
  input wire logic csr_rd_in,
  input wire logic data_wr_in,
  input wire logic data_rd_in,
  input wire logic [7:0] wdata_in,
  input wire logic cpu_irq_mask_in,
  // Register views
  output logic [7:0] serial_control_reg_out,
  output logic [7:0] serial_ctrl_status_reg_out,
  output logic [7:0] serial_data_reg_out,
  output logic irq_out,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic ss_n_in
);
  logic [7:0] ctl_reg;
  logic done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg, ssm_reg, ssi_reg;
  logic done_armed_reg, mode_fault_flag_armed_reg, write_collision_flag_armed_reg;
  spimsp_pkg::spimsp_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [3:0] bits_reg;
  logic [4:0] edges_reg;
  logic first_reg;
  logic [1:0] cap_dly_reg;
  logic [6:0] div_reg;
  logic sck_drv_reg;
  logic [7:0] rx_hold_reg;
  logic ovr_lock_reg;
  spimsp_pkg::spimsp_pins_t s1_reg, s2_reg;
  logic sck_prev_reg;
  // Synchronise pins; only stage two is read
  always_ff @(posedge core_clk_in) begin
    s1_reg <= '{clk: sck_in, mosi: mosi_in, miso: miso_in, sel_n: ss_n_in};
    s2_reg <= s1_reg;
    sck_prev_reg <= s2_reg.clk;
  end
  wire enable = ctl_reg[`SPIMSP_CTL_ENABLE];
  wire master = ctl_reg[`SPIMSP_CTL_MASTER];
  wire clock_polarity = ctl_reg[`SPIMSP_CTL_CLOCK_POLARITY];
  wire clock_phase = ctl_reg[`SPIMSP_CTL_CLOCK_PHASE];
  wire sel_n = ssm_reg ? ssi_reg : s2_reg.sel_n;
  wire mode_fault = enable && master && !sel_n;
  wire [2:0] rate_sel = {ctl_reg[`SPIMSP_CTL_RATE2], ctl_reg[1:0]};
  // Half period less one in core cycles, divide by 4 up to 128
  wire [6:0] half_per = (rate_sel == 3'b100) ? 7'd1 :
                        (rate_sel == 3'b000) ? 7'd3 :
                        (rate_sel == 3'b001) ? 7'd7 :
                        (rate_sel == 3'b110) ? 7'd15 :
                        (rate_sel == 3'b010) ? 7'd31 : 7'd63;
  wire busy = (state_reg == spimsp_pkg::SPIMSP_SHIFT);
  // Ticks stop after sixteen edges so a late last sample adds none
  wire tick = master && busy && (div_reg == half_per) && (edges_reg != 5'h10);
  // Slave edges from the sampled clock
  wire sl_edge = !master && enable && !sel_n && (s2_reg.clk != sck_prev_reg);
  // Only an edge leaving the idle level opens a slave frame
  wire sl_lead = sl_edge && (s2_reg.clk != clock_polarity);
  wire any_edge = tick || sl_edge;
  // First edge samples when phase is 0, second when phase is 1
  wire capture = any_edge && (edges_reg[0] == clock_phase);
  wire launch = any_edge && !capture;
  wire tx_shift = launch && !first_reg;
  // Master input lags its own clock by the two sync flops
  wire rx_sample = master ? cap_dly_reg[1] : capture;
  wire rx_bit = master ? s2_reg.miso : s2_reg.mosi;
  wire last_bit = rx_sample && (bits_reg == `SPIMSP_BITS - 4'h1);
  wire [7:0] rx_byte = {shift_reg[6:0], rx_bit};
  wire data_wr_ok = data_wr_in && !(done_reg && !done_armed_reg);
  wire collide = data_wr_ok && busy;
  wire load = data_wr_ok && !busy && enable;
  wire start = master ? load : (sl_lead && state_reg == spimsp_pkg::SPIMSP_IDLE);
  wire clr_done = done_reg && done_armed_reg && (data_wr_in || data_rd_in);
  wire clr_mode_fault_flag = mode_fault_flag_armed_reg && ctl_wr_in;
  // Fault bars enable and master except in the clearing write
  wire [7:0] ctl_wr_val = (mode_fault_flag_reg && !clr_mode_fault_flag) ?
    (wdata_in & 8'haf) : wdata_in;
  logic buf_in_ready, buf_out_valid;
  logic [7:0] buf_data;
  wire push = last_bit && !(done_reg && !clr_done);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctl_reg <= `SPIMSP_CTL_RESET;
    end else if (mode_fault) begin
      ctl_reg[`SPIMSP_CTL_ENABLE] <= 1'b0;
      ctl_reg[`SPIMSP_CTL_MASTER] <= 1'b0;
    end else if (ctl_wr_in) begin
      ctl_reg <= ctl_wr_val;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg} <= 4'h0;
      {ssm_reg, ssi_reg} <= 2'h0;
      {done_armed_reg, mode_fault_flag_armed_reg, write_collision_flag_armed_reg} <= 3'h0;
    end else begin
      if (csr_wr_in) begin
        ssm_reg <= wdata_in[`SPIMSP_CSR_SSM];
        ssi_reg <= wdata_in[`SPIMSP_CSR_SSI];
      end
      // Set wins over clear everywhere
      if (last_bit) done_reg <= 1'b1;
      else if (clr_done) done_reg <= 1'b0;
      if ((csr_rd_in || csr_wr_in) && done_reg) done_armed_reg <= 1'b1;
      else if (clr_done) done_armed_reg <= 1'b0;
      if (last_bit && done_reg && !clr_done) ovr_reg <= 1'b1;
      else if (csr_rd_in) ovr_reg <= 1'b0;
      if (mode_fault) mode_fault_flag_reg <= 1'b1;
      else if (clr_mode_fault_flag) mode_fault_flag_reg <= 1'b0;
      if (csr_rd_in && mode_fault_flag_reg) mode_fault_flag_armed_reg <= 1'b1;
      else if (ctl_wr_in) mode_fault_flag_armed_reg <= 1'b0;
      if (collide) write_collision_flag_reg <= 1'b1;
      else if (write_collision_flag_armed_reg && (data_wr_in || data_rd_in)) write_collision_flag_reg <= 1'b0;
      if (csr_rd_in && write_collision_flag_reg) write_collision_flag_armed_reg <= 1'b1;
      else if (data_wr_in || data_rd_in) write_collision_flag_armed_reg <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= spimsp_pkg::SPIMSP_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      bits_reg <= 4'h0;
      edges_reg <= 5'h00;
      first_reg <= 1'b1;
      cap_dly_reg <= 2'h0;
      div_reg <= 7'h00;
      sck_drv_reg <= 1'b0;
    end else begin
      // Outgoing bit moves only on launch edges, never on capture
      if (load) tx_reg <= wdata_in;
      else if (tx_shift) tx_reg <= {tx_reg[6:0], 1'b0};
      cap_dly_reg <= {cap_dly_reg[0], capture && master};
      if (rx_sample) shift_reg <= rx_byte;
      case (state_reg)
        spimsp_pkg::SPIMSP_IDLE: begin
          sck_drv_reg <= clock_polarity;
          edges_reg <= 5'h00;
          first_reg <= 1'b1;
          bits_reg <= 4'h0;
          div_reg <= 7'h00;
          if (start && enable) begin
            state_reg <= spimsp_pkg::SPIMSP_SHIFT;
            // Slave frame opens on an edge that already counts
            if (!master) begin
              edges_reg <= 5'h01;
              first_reg <= 1'b0;
              if (capture) bits_reg <= 4'h1;
            end
          end
        end
        spimsp_pkg::SPIMSP_SHIFT: begin
          div_reg <= tick ? 7'h00 : div_reg + 7'h01;
          if (tick) sck_drv_reg <= ~sck_drv_reg;
          if (any_edge) begin
            edges_reg <= edges_reg + 5'h01;
            first_reg <= 1'b0;
          end
          if (rx_sample) bits_reg <= bits_reg + 4'h1;
          if (last_bit) state_reg <= spimsp_pkg::SPIMSP_DONE;
          if (!enable) state_reg <= spimsp_pkg::SPIMSP_IDLE;
        end
        spimsp_pkg::SPIMSP_DONE: begin
          // Trailing half clock so master ends at idle level
          div_reg <= div_reg + 7'h01;
          if (!master || div_reg >= half_per) begin
            sck_drv_reg <= clock_polarity;
            state_reg <= spimsp_pkg::SPIMSP_IDLE;
          end
        end
        default: state_reg <= spimsp_pkg::SPIMSP_IDLE;
      endcase
    end
  end
  // Buffer keeps the first byte after done was cleared
  spimsp_buf u_rx_buf (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(push),
    .in_ready_out(buf_in_ready),
    .in_data_in(rx_byte),
    .out_valid_out(buf_out_valid),
    .out_ready_in(data_rd_in || !ovr_lock_reg),
    .out_data_out(buf_data)
  );
  // Read side only sees the held register, never the shifter
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rx_hold_reg <= 8'h00;
      ovr_lock_reg <= 1'b0;
    end else begin
      if (buf_out_valid && (data_rd_in || !ovr_lock_reg)) begin
        rx_hold_reg <= buf_data;
        ovr_lock_reg <= 1'b1;
      end else if (data_rd_in) begin
        ovr_lock_reg <= 1'b0;
      end
    end
  end
  assign serial_control_reg_out = ctl_reg;
  assign serial_ctrl_status_reg_out = {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg,
                                      2'h0, ssm_reg, ssi_reg};
  assign serial_data_reg_out = rx_hold_reg;
  assign irq_out = ctl_reg[`SPIMSP_CTL_IRQ_EN] && !cpu_irq_mask_in &&
                   (done_reg || ovr_reg || mode_fault_flag_reg);
  // Pins; MSB of the shifter is always the outgoing bit
  assign sck_out = sck_drv_reg;
  assign sck_oe_out = enable && master;
  assign mosi_out = tx_reg[7];
  assign mosi_oe_out = enable && master;
  assign miso_out = tx_reg[7];
  assign miso_oe_out = enable && !master && !sel_n;
  wire unused_ok = buf_in_ready;
  // Checks
  fault_drops_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    mode_fault |=> !ctl_reg[`SPIMSP_CTL_ENABLE] && mode_fault_flag_reg)
    else $error("fault did not drop enable");
  done_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    last_bit |=> done_reg)
    else $error("done not set");
  ovr_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (last_bit && done_reg && !clr_done) |=> ovr_reg)
    else $error("overrun missed");
  ovr_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (csr_rd_in && !last_bit) |=> !ovr_reg)
    else $error("overrun not cleared");
  write_collision_flag_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    collide |=> write_collision_flag_reg)
    else $error("collision missed");
  tx_kept_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (collide && !tx_shift) |=> tx_reg == $past(tx_reg))
    else $error("collision changed shifter");
  write_collision_flag_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (write_collision_flag_reg && !done_reg && !ovr_reg && !mode_fault_flag_reg) |-> !irq_out)
    else $error("collision raised interrupt");
  irq_done_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (done_reg && ctl_reg[`SPIMSP_CTL_IRQ_EN] && !cpu_irq_mask_in) |-> irq_out)
    else $error("done without interrupt");
  irq_masked_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cpu_irq_mask_in |-> !irq_out)
    else $error("masked interrupt seen");
  pins_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !enable |-> !sck_oe_out && !mosi_oe_out && !miso_oe_out)
    else $error("pins driven while disabled");
  load_msb_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    load |=> mosi_out == $past(wdata_in[7]))
    else $error("first bit not on data line");
  edge_bound_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    edges_reg <= 5'h10)
    else $error("too many clock edges");
  ovr_drops_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (last_bit && done_reg && !clr_done) |-> !push)
    else $error("overrun byte kept");
  mode_fault_flag_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (clr_mode_fault_flag && !mode_fault) |=> !mode_fault_flag_reg)
    else $error("fault not cleared");
  mode_fault_flag_holds_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    mode_fault_flag_reg |-> !ctl_reg[`SPIMSP_CTL_ENABLE] && !ctl_reg[`SPIMSP_CTL_MASTER])
    else $error("enable kept under fault");
  trail_no_start_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_reg == spimsp_pkg::SPIMSP_IDLE && !master && s2_reg.clk == clock_polarity)
    |=> state_reg != spimsp_pkg::SPIMSP_SHIFT)
    else $error("slave started on trailing edge");
  sck_steady_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (master && busy && !tick) |=> sck_out == $past(sck_out))
    else $error("clock moved without tick");
  ovr_with_done_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(ovr_reg) |-> done_reg)
    else $error("overrun without done");
  done_stays_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (done_reg && !clr_done) |=> done_reg)
    else $error("done lost early");
  mode_fault_flag_blocks_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (mode_fault_flag_reg && ctl_wr_in && !clr_mode_fault_flag) |=> !ctl_reg[`SPIMSP_CTL_MASTER])
    else $error("master set under fault");
  done_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (clr_done && !last_bit) |=> !done_reg)
    else $error("done not cleared");
  wr_ignored_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (data_wr_in && done_reg && !done_armed_reg) |-> !load)
    else $error("write not ignored");
  sck_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (state_reg == spimsp_pkg::SPIMSP_IDLE) |=> sck_out == $past(clock_polarity))
    else $error("clock not idle");
  master_xfer_c: cover property (@(posedge core_clk_in) master && last_bit);
  slave_xfer_c: cover property (@(posedge core_clk_in) !master && last_bit);
  overrun_c: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ovr_reg && done_reg);
  fault_c: cover property (@(posedge core_clk_in) mode_fault);
endmodule
`default_nettype wire

/* tb/spimsp_peer.sv */
// Purpose: Far-side serial device, as slave or as master
// Assumes: Bench resolves the shared pins
// Notes: Released data lines rotate an inverted pattern
`timescale 1ns/100ps
`default_nettype none
module spimsp_peer (
  // Timing setup
  input wire logic clock_polarity_in,
  input wire logic clock_phase_in,
  // Pins
  input wire spimsp_pkg::spimsp_pins_t pin_in,
  output var spimsp_pkg::spimsp_pins_t pin_out
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic drv = 1'b0;
  int e = 0;
  initial pin_out = 4'h7;
  // Pull resistor sets the idle level while nobody drives
  always @(clock_polarity_in) if (!drv) pin_out.clk = clock_polarity_in;
  task automatic load(input logic [7:0] tx, output logic b);
    sh = clock_phase_in ? tx : {tx[6:0], ~tx[7]};
    b = clock_phase_in ? ~tx[7] : tx[7];
  endtask
  task automatic arm(input logic [7:0] tx);
    e = 0;
    load(tx, pin_out.miso);
  endtask
  // Slave role: capture on the phase edge, shift on the other
  always @(pin_in.clk) if (!drv) begin
    e = e + 1;
    if (e[0] != clock_phase_in) rx = {rx[6:0], pin_in.mosi};
    else begin
      pin_out.miso = sh[7];
      sh = {sh[6:0], ~sh[7]};
    end
  end
  // Master role: 80 ns clock only inside the frame
  task automatic send(input logic [7:0] tx, output logic [7:0] got);
    got = 8'h00;
    drv = 1'b1;
    pin_out.sel_n = 1'b0;
    load(tx, pin_out.mosi);
    for (int k = 1; k <= 16; k++) begin
      #40;
      pin_out.clk = ~pin_out.clk;
      if (k[0] != clock_phase_in) got = {got[6:0], pin_in.miso};
      else begin
        pin_out.mosi = sh[7];
        sh = {sh[6:0], ~sh[7]};
      end
    end
    #40;
    pin_out.sel_n = 1'b1;
    pin_out.mosi = ~pin_out.mosi;
    drv = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb_spimsp_core.sv */
// Purpose: Self-checking bench for the serial port core
// Assumes: Peer model stands on the serial pins
// Notes: Master bytes come from a table, faults by hand
`timescale 1ns/100ps
`default_nettype none
module tb_spimsp_core;
  localparam int CW = 0, SW = 1, SR = 2, DW = 3, DR = 4;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] stb = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic mask = 1'b0;
  logic ss_drv = 1'b1;
  logic clock_polarity = 1'b0;
  logic clock_phase = 1'b0;
  logic [7:0] got, ctl, csr, dat;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  spimsp_pkg::spimsp_pins_t pins, peer;
  int n_errors = 0;
  int samples_checked = 0;
  // Control, byte out, peer byte, half period in core cycles
  logic [31:0] rows [6] = '{32'hf0a53c02, 32'hd4817e04, 32'hd9018008,
    32'hfec35a10, 32'hd2ff0020, 32'hd3699640};
  assign pins = {sck_oe ? sck_o : peer.clk, mosi_oe ? mosi_o : peer.mosi,
    miso_oe ? miso_o : peer.miso, peer.sel_n & ss_drv};
  always #5 core_clk = ~core_clk;
  spimsp_core u_spimsp_core (.core_clk_in(core_clk), .rst_n_in(rst_n), .ctl_wr_in(stb[0]),
    .csr_wr_in(stb[1]), .csr_rd_in(stb[2]), .data_wr_in(stb[3]), .data_rd_in(stb[4]),
    .wdata_in(wdata), .cpu_irq_mask_in(mask), .serial_control_reg_out(ctl),
    .serial_ctrl_status_reg_out(csr), .serial_data_reg_out(dat), .irq_out(irq),
    .sck_in(pins.clk), .sck_out(sck_o), .sck_oe_out(sck_oe), .mosi_in(pins.mosi),
    .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(pins.miso), .miso_out(miso_o),
    .miso_oe_out(miso_oe), .ss_n_in(pins.sel_n));
  spimsp_peer u_spimsp_peer (.clock_polarity_in(clock_polarity), .clock_phase_in(clock_phase), .pin_in(pins), .pin_out(peer));
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  // One-cycle strobe; ends off the edge so results have landed
  task automatic op(input int k, input logic [7:0] d);
    @(posedge core_clk);
    stb[k] <= 1'b1;
    wdata <= d;
    @(posedge core_clk);
    stb[k] <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic run(input int half);
    int tg = 0;
    int t1 = 0;
    int tl = 0;
    int tail = 0;
    logic pv = sck_o;
    // Last edge may follow the done flag, so keep watching a while
    for (int i = 0; i < 4200 && tail < 140; i++) begin
      @(negedge core_clk);
      if (csr[7] === 1'b1) tail++;
      if (sck_o !== pv) begin
        tg++;
        if (tg == 1) t1 = i;
        tl = i;
      end
      pv = sck_o;
    end
    if (csr[7] !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      print_verdict();
    end
    chk(16'(tg), 16'h0010);
    chk(16'(tl - t1), 16'(15 * half));
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk({ctl, csr}, 16'h0000);
    chk(16'({dat, sck_oe, mosi_oe, miso_oe}), 16'h0000);
    foreach (rows[r]) begin
      op(CW, 8'h00);
      clock_polarity = rows[r][27];
      clock_phase = rows[r][26];
      op(SW, 8'h03);
      op(CW, rows[r][31:24]);
      chk(16'(ctl), 16'(rows[r][31:24]));
      repeat (4) @(negedge core_clk);
      u_spimsp_peer.arm(rows[r][15:8]);
      op(DW, rows[r][23:16]);
      fork
        begin
          repeat (3) @(posedge core_clk);
          op(DW, 8'h00);
        end
      join_none
      run(int'(rows[r][7:0]));
      chk(16'(u_spimsp_peer.rx), 16'(rows[r][23:16]));
      chk({csr, 7'h00, irq & sck_oe}, 16'hc301);
      op(SR, 8'h00);
      op(DR, 8'h00);
      chk({dat, 7'h00, irq}, {rows[r][15:8], 8'h00});
      chk(16'(csr), 16'h0003);
    end
    op(CW, 8'hf0);
    u_spimsp_peer.arm(8'h00);
    op(DW, 8'h11);
    run(2);
    @(posedge core_clk);
    mask <= 1'b1;
    op(DW, 8'h22);
    repeat (40) @(negedge core_clk);
    chk(16'(u_spimsp_peer.e), 16'h0010);
    chk(16'(irq), 16'h0000);
    op(SR, 8'h00);
    op(DR, 8'h00);
    op(SW, 8'h00);
    @(posedge core_clk);
    mask <= 1'b0;
    ss_drv <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk({ctl, csr}, 16'ha010);
    chk(16'(irq), 16'h0001);
    @(posedge core_clk);
    ss_drv <= 1'b1;
    op(CW, 8'hf0);
    chk({ctl, csr}, 16'ha010);
    op(SR, 8'h00);
    op(CW, 8'hf0);
    chk({ctl, csr}, 16'hf000);
    op(CW, 8'hc0);
    op(DW, 8'hc3);
    u_spimsp_peer.send(8'h3c, got);
    repeat (6) @(negedge core_clk);
    chk({got, csr}, 16'hc380);
    chk(16'(dat), 16'h003c);
    u_spimsp_peer.send(8'h77, got);
    repeat (6) @(negedge core_clk);
    chk({csr, 7'h00, irq}, 16'ha001);
    op(DR, 8'h00);
    chk(16'(dat), 16'h003c);
    op(SR, 8'h00);
    chk(16'(csr), 16'h0080);
    print_verdict();
  end
endmodule
`default_nettype wire
